// ==== pkg/lock_map_pkg.sv ====
// Constants for the block-to-lock-bit map and its parameter table sections
package lock_map_pkg;

    // ------------------------------------------------------------
    // Density exponent limits
    // ------------------------------------------------------------
    localparam int M_MIN     = 4;
    localparam int M_MAX     = 8;
    localparam int M_DEFAULT = 7;

    // ------------------------------------------------------------
    // Block geometry (address bit shifts)
    // ------------------------------------------------------------
    localparam int SHIFT_8K  = 13;
    localparam int SHIFT_32K = 15;
    localparam int SHIFT_64K = 16;

    // ------------------------------------------------------------
    // Sector type codes
    // ------------------------------------------------------------
    localparam logic [7:0] TYPE_8K  = 8'h02;
    localparam logic [7:0] TYPE_32K = 8'h03;
    localparam logic [7:0] TYPE_64K = 8'h04;

    // ------------------------------------------------------------
    // Sector count exponents (count = 2**n)
    // ------------------------------------------------------------
    localparam logic [7:0] CNT_EXP_8K  = 8'h02;
    localparam logic [7:0] CNT_EXP_32K = 8'h00;

    // ------------------------------------------------------------
    // Signed lock-bit adders
    // ------------------------------------------------------------
    localparam logic [7:0] ADD_ZERO     = 8'h00;
    localparam logic [7:0] ADD_B8_FIRST = 8'hFF;
    localparam logic [7:0] ADD_B8_LAST  = 8'h06;
    localparam logic [7:0] ADD_B32      = 8'hFD;
    localparam logic [7:0] ADD_64_LAST  = 8'hFC;
    localparam logic [7:0] ADD_T32      = 8'hFE;
    localparam logic [7:0] ADD_T8_FIRST = 8'h07;
    localparam logic [7:0] ADD_T8_LAST  = 8'h0E;

    // ------------------------------------------------------------
    // Section numbers and field order inside a section
    // ------------------------------------------------------------
    localparam logic [2:0] SEC_B8  = 3'h1;
    localparam logic [2:0] SEC_B32 = 3'h2;
    localparam logic [2:0] SEC_64  = 3'h3;
    localparam logic [2:0] SEC_T32 = 3'h4;
    localparam logic [2:0] SEC_T8  = 3'h5;

    localparam logic [1:0] FLD_TYPE  = 2'h0;
    localparam logic [1:0] FLD_COUNT = 2'h1;
    localparam logic [1:0] FLD_FIRST = 2'h2;
    localparam logic [1:0] FLD_LAST  = 2'h3;

    localparam logic [7:0] BYTE_NONE = 8'h00;

endpackage : lock_map_pkg

// ==== logic/sector_lock_bit_map.sv ====
// Address-to-lock-bit mapping and section table content of the flash array
`timescale 1ns/100ps
// Functional notes
// - Bottom up: four 8K, one 32K, 64K run, one 32K, four 8K blocks.
// - Sector type 2 for 8K, 3 for 32K, 4 for 64K blocks.
// - Number of 64K blocks is two to the m, minus two.
// - m is 4,5,6,7,8 for 8,16,32,64,128 Mbit densities.
// - 8K and 32K section counts are two to the count exponent.
// - Nonzero first/last byte is signed adder; bit is 2**m + 1 + c.
// - Adder byte top bit is the sign; set means negative.
// - Last field names the bit guarding the section's last block.
// - 64K section first bit is 0 (byte zero); last adder is minus four.
// - Bottom 32K block uses one bit, adder minus three both fields.
// - Top 32K block uses one bit, adder minus two both fields.
// - Bottom 8K first adder minus one; last adder taken as six.
// - Top 8K first adder plus seven, last adder plus fourteen.
// - In 8K sections odd bits lock reads, even bits lock writes.
// - Bits step by one from first to last, one per lock bit.
// - Section entry is type, count, first bit, last bit in order.

module sector_lock_bit_map
    import lock_map_pkg::*;
#(
    parameter int DENSITY_EXP = M_DEFAULT,
    parameter int AW          = DENSITY_EXP + SHIFT_64K,
    parameter int NLB         = (2 ** DENSITY_EXP) + 16,
    parameter int LW          = DENSITY_EXP + 1
) (
    input  wire logic           mclk_i,
    input  wire logic           resetn_i,
    input  wire logic           check_i,
    input  wire logic [AW-1:0]  addr_i,
    input  wire logic [NLB-1:0] lock_bits_i,
    input  wire logic [2:0]     tbl_section_i,
    input  wire logic [1:0]     tbl_field_i,
    output logic                check_done_o,
    output logic [LW-1:0]       lock_index_o,
    output logic [7:0]          block_type_o,
    output logic                write_locked_o,
    output logic                read_locked_o,
    output logic [7:0]          tbl_byte_o
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (DENSITY_EXP < M_MIN || DENSITY_EXP > M_MAX) begin : g_bad_m
        $error("density exponent out of range");
    end
    if (AW != DENSITY_EXP + SHIFT_64K || NLB != (2 ** DENSITY_EXP) + 16
        || LW != DENSITY_EXP + 1) begin : g_bad_w
        $error("derived widths must not be overridden");
    end

    // ------------------------------------------------------------
    // Adder decoding
    // ------------------------------------------------------------
    // Sixteen-bit signed sum: a negative adder never wraps the index
    function automatic logic [LW-1:0] bit_from_adder(input logic [7:0] c);
        logic signed [15:0] s;
        s = 16'((2 ** DENSITY_EXP) + 1) + {{8{c[7]}}, c};
        if (c == ADD_ZERO) begin
            return '0;
        end
        return s[LW-1:0];
    endfunction : bit_from_adder

    localparam logic [LW-1:0] B8_FIRST  = bit_from_adder(ADD_B8_FIRST);
    localparam logic [LW-1:0] B8_LAST   = bit_from_adder(ADD_B8_LAST);
    localparam logic [LW-1:0] B32_BIT   = bit_from_adder(ADD_B32);
    localparam logic [LW-1:0] L64_LAST  = bit_from_adder(ADD_64_LAST);
    localparam logic [LW-1:0] T32_BIT   = bit_from_adder(ADD_T32);
    localparam logic [LW-1:0] T8_FIRST  = bit_from_adder(ADD_T8_FIRST);
    localparam logic [LW-1:0] T8_LAST   = bit_from_adder(ADD_T8_LAST);
    localparam logic [7:0]    CNT_64K   = 8'((2 ** DENSITY_EXP) - 2);
    localparam int            RW        = AW - SHIFT_32K;
    localparam logic [RW-1:0] REG_B8    = '0;
    localparam logic [RW-1:0] REG_B32   = RW'(1);
    localparam logic [RW-1:0] REG_T8    = '1;
    localparam logic [RW-1:0] REG_T32   = REG_T8 - RW'(1);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [RW-1:0] region;
    logic [1:0]    sub8;
    logic [LW-1:0] idx_d;
    logic [7:0]    type_d;
    logic          is8_d;

    assign region = addr_i[AW-1:SHIFT_32K];
    assign sub8   = addr_i[SHIFT_32K-1:SHIFT_8K];

    // Bits below the block shift are ignored, so 4K sectors share a bit
    always_comb begin
        type_d = TYPE_64K;
        is8_d  = 1'b0;
        idx_d  = LW'(addr_i[AW-1:SHIFT_64K]) - LW'(1);
        if (region == REG_B8) begin
            type_d = TYPE_8K;
            is8_d  = 1'b1;
            idx_d  = B8_FIRST + LW'({sub8, 1'b0});
        end else if (region == REG_B32) begin
            type_d = TYPE_32K;
            idx_d  = B32_BIT;
        end else if (region == REG_T8) begin
            type_d = TYPE_8K;
            is8_d  = 1'b1;
            idx_d  = T8_FIRST + LW'({sub8, 1'b0});
        end else if (region == REG_T32) begin
            type_d = TYPE_32K;
            idx_d  = T32_BIT;
        end
    end

    // ------------------------------------------------------------
    // Lock lookup result
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            check_done_o <= 1'b0;
        end else begin
            check_done_o <= check_i;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_index_o   <= '0;
            block_type_o   <= BYTE_NONE;
            write_locked_o <= 1'b0;
            read_locked_o  <= 1'b0;
        end else if (check_i) begin
            lock_index_o   <= idx_d;
            block_type_o   <= type_d;
            write_locked_o <= lock_bits_i[idx_d];
            // Only parameter blocks carry a read lock, in the odd bit above
            read_locked_o  <= is8_d & lock_bits_i[idx_d+LW'(1)];
        end
    end

    // ------------------------------------------------------------
    // Section table bytes
    // ------------------------------------------------------------
    logic [7:0] tbl_d;

    always_comb begin
        tbl_d = BYTE_NONE;
        unique case (tbl_section_i)
            SEC_B8, SEC_T8: begin
                unique case (tbl_field_i)
                    FLD_TYPE:  tbl_d = TYPE_8K;
                    FLD_COUNT: tbl_d = CNT_EXP_8K;
                    FLD_FIRST: tbl_d = (tbl_section_i == SEC_B8) ? ADD_B8_FIRST
                                                                 : ADD_T8_FIRST;
                    FLD_LAST:  tbl_d = (tbl_section_i == SEC_B8) ? ADD_B8_LAST
                                                                 : ADD_T8_LAST;
                endcase
            end
            SEC_B32, SEC_T32: begin
                unique case (tbl_field_i)
                    FLD_TYPE:  tbl_d = TYPE_32K;
                    FLD_COUNT: tbl_d = CNT_EXP_32K;
                    FLD_FIRST,
                    FLD_LAST:  tbl_d = (tbl_section_i == SEC_B32) ? ADD_B32
                                                                  : ADD_T32;
                endcase
            end
            SEC_64: begin
                unique case (tbl_field_i)
                    FLD_TYPE:  tbl_d = TYPE_64K;
                    FLD_COUNT: tbl_d = CNT_64K;
                    FLD_FIRST: tbl_d = ADD_ZERO;
                    FLD_LAST:  tbl_d = ADD_64_LAST;
                endcase
            end
            default: tbl_d = BYTE_NONE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tbl_byte_o <= BYTE_NONE;
        end else begin
            tbl_byte_o <= tbl_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence req_b8_s;
        check_i && region == REG_B8;
    endsequence

    sequence req_t8_s;
        check_i && region == REG_T8;
    endsequence

    sequence req_64_s;
        check_i && region != REG_B8 && region != REG_B32
            && region != REG_T8 && region != REG_T32;
    endsequence

    sequence tbl_64_last_s;
        tbl_section_i == SEC_64 && tbl_field_i == FLD_LAST;
    endsequence

    sequence tbl_8k_s;
        tbl_section_i == SEC_B8 || tbl_section_i == SEC_T8;
    endsequence

    sequence tbl_32k_s;
        tbl_section_i == SEC_B32 || tbl_section_i == SEC_T32;
    endsequence

    // Both fields of the bottom 32K block must name the same bit
    sequence b32_pair_s;
        tbl_section_i == SEC_B32 && tbl_field_i == FLD_FIRST
            ##1 tbl_section_i == SEC_B32 && tbl_field_i == FLD_LAST;
    endsequence

    done_follows_a: assert property (check_i |=> check_done_o)
        else $error("done not raised after check");

    // A stale done would make a host take an old result as fresh
    done_pulse_a: assert property (!check_i |=> !check_done_o)
        else $error("done raised without check");

    bot8_index_a: assert property (req_b8_s |=> lock_index_o == B8_FIRST
        + LW'({$past(sub8), 1'b0}) && block_type_o == TYPE_8K)
        else $error("bottom 8K lock index wrong");

    top8_read_a: assert property (req_t8_s |=> read_locked_o
        == $past(lock_bits_i[T8_FIRST + LW'({sub8, 1'b1})]))
        else $error("top 8K read lock not from odd bit");

    run64_index_a: assert property (req_64_s |=> block_type_o == TYPE_64K
        && lock_index_o <= L64_LAST && !read_locked_o)
        else $error("64K block index out of span");

    first64_bit_a: assert property (check_i && addr_i[AW-1:SHIFT_64K] == 1
        |=> lock_index_o == '0)
        else $error("first 64K block not bit 0");

    bot32_bit_a: assert property (check_i && region == REG_B32 |=> lock_index_o
        == LW'((2 ** DENSITY_EXP) - 2) && block_type_o == TYPE_32K)
        else $error("bottom 32K lock bit wrong");

    top32_bit_a: assert property (check_i && region == REG_T32
        |=> lock_index_o == LW'((2 ** DENSITY_EXP) - 1))
        else $error("top 32K lock bit wrong");

    write_lock_a: assert property (check_i
        |=> write_locked_o == $past(lock_bits_i[idx_d]))
        else $error("write lock not from mapped bit");

    span64_a: assert property (tbl_64_last_s |=> bit_from_adder(tbl_byte_o) + LW'(1)
        == LW'(CNT_64K))
        else $error("64K span differs from block count");

    top8_last_a: assert property (tbl_section_i == SEC_T8 && tbl_field_i == FLD_LAST
        |=> bit_from_adder(tbl_byte_o) == T8_LAST && T8_LAST - T8_FIRST == LW'(7))
        else $error("top 8K last bit wrong");

    hold_idle_a: assert property (!check_i |=> $stable(lock_index_o)
        && $stable(write_locked_o))
        else $error("result changed without check");

    bot8_read_a: assert property (req_b8_s |=> read_locked_o
        == $past(lock_bits_i[B8_FIRST + LW'({sub8, 1'b1})]))
        else $error("bottom 8K read lock not from odd bit");

    top8_index_a: assert property (req_t8_s |=> lock_index_o == T8_FIRST
        + LW'({$past(sub8), 1'b0}) && block_type_o == TYPE_8K)
        else $error("top 8K lock index wrong");

    // Only parameter blocks have a read lock; a stray one would block reads
    wide_read_a: assert property (check_i && region != REG_B8 && region != REG_T8
        |=> !read_locked_o)
        else $error("read lock outside 8K blocks");

    run64_step_a: assert property (req_64_s |=> lock_index_o + LW'(1)
        == LW'($past(addr_i[AW-1:SHIFT_64K])))
        else $error("64K blocks do not step by one bit");

    type8_byte_a: assert property (tbl_8k_s ##0 tbl_field_i == FLD_TYPE
        |=> tbl_byte_o == TYPE_8K)
        else $error("8K section type byte wrong");

    count8_byte_a: assert property (tbl_8k_s ##0 tbl_field_i == FLD_COUNT
        |=> (LW'(1) << tbl_byte_o) == LW'(4))
        else $error("8K section does not count four blocks");

    count32_byte_a: assert property (tbl_32k_s ##0 tbl_field_i == FLD_COUNT
        |=> (LW'(1) << tbl_byte_o) == LW'(1))
        else $error("32K section does not count one block");

    b32_pair_a: assert property (b32_pair_s |=> tbl_byte_o == $past(tbl_byte_o))
        else $error("bottom 32K first and last bits differ");

    bad_section_a: assert property (tbl_section_i < SEC_B8 || tbl_section_i > SEC_T8
        |=> tbl_byte_o == BYTE_NONE)
        else $error("unknown section not zero");

endmodule : sector_lock_bit_map

// ==== verif/lock_host_model.sv ====
// Host-side decoder turning a section table adder byte into a lock-bit index
`timescale 1ns/100ps
module lock_host_model #(
    parameter int M = 7
) (
    input  wire logic [7:0] adder_i,
    output logic      [9:0] bit_index_o
);
    // Ten signed bits so a negative adder on 2**m + 1 never wraps
    logic signed [9:0] base;
    assign base = 10'(2 ** M) + 10'h001;
    always_comb begin
        if (adder_i == 8'h00) begin
            bit_index_o = 10'h000;
        end else begin
            bit_index_o = base + {{2{adder_i[7]}}, adder_i};
        end
    end
endmodule : lock_host_model

// ==== verif/sector_lock_bit_map_tb_top.sv ====
// Self-checking bench for the lock-bit map and its section table
`timescale 1ns/100ps
module sector_lock_bit_map_tb_top
    import lock_map_pkg::*;
;
    localparam int M   = 7;
    localparam int AW  = M + SHIFT_64K;
    localparam int NLB = (2 ** M) + 16;
    localparam int LW  = M + 1;
    typedef struct packed { logic [22:0] addr; logic [7:0] idx; logic [7:0] typ; } row_t;
    logic           mclk = 1'b0;
    logic           resetn = 1'b0;
    logic           check = 1'b0;
    logic [AW-1:0]  addr = '0;
    logic [NLB-1:0] lock_bits = '0;
    logic [2:0]     tbl_section = 3'h1;
    logic [1:0]     tbl_field = 2'h0;
    logic           check_done;
    logic [LW-1:0]  lock_index;
    logic [7:0]     block_type;
    logic           wr_locked;
    logic           rd_locked;
    logic [7:0]     tbl_byte;
    logic [9:0]     host_bit;
    int             n_errors = 0;
    int             samples_checked = 0;
    // 4K addresses inside a block must fall back on that block's bit
    row_t rows [9] = '{
        '{23'h00_0000, 8'h80, TYPE_8K},  '{23'h00_6000, 8'h86, TYPE_8K},
        '{23'h00_8000, 8'h7E, TYPE_32K}, '{23'h01_0000, 8'h00, TYPE_64K},
        '{23'h01_F000, 8'h00, TYPE_64K}, '{23'h7E_0000, 8'h7D, TYPE_64K},
        '{23'h7F_0000, 8'h7F, TYPE_32K}, '{23'h7F_8000, 8'h88, TYPE_8K},
        '{23'h7F_E000, 8'h8E, TYPE_8K}};
    logic [7:0] exp_tbl [1:5][4] = '{'{8'h02, 8'h02, 8'hFF, 8'h06},
        '{8'h03, 8'h00, 8'hFD, 8'hFD}, '{8'h04, 8'h7E, 8'h00, 8'hFC},
        '{8'h03, 8'h00, 8'hFE, 8'hFE}, '{8'h02, 8'h02, 8'h07, 8'h0E}};
    logic [9:0] exp_bit [1:5][2] = '{'{10'h080, 10'h087}, '{10'h07E, 10'h07E},
        '{10'h000, 10'h07D}, '{10'h07F, 10'h07F}, '{10'h088, 10'h08F}};

    always #2 mclk = ~mclk;

    sector_lock_bit_map #(.DENSITY_EXP(M)) dut (
        .mclk_i(mclk), .resetn_i(resetn), .check_i(check), .addr_i(addr),
        .lock_bits_i(lock_bits), .tbl_section_i(tbl_section), .tbl_field_i(tbl_field),
        .check_done_o(check_done), .lock_index_o(lock_index), .block_type_o(block_type),
        .write_locked_o(wr_locked), .read_locked_o(rd_locked), .tbl_byte_o(tbl_byte));

    lock_host_model #(.M(M)) host (.adder_i(tbl_byte), .bit_index_o(host_bit));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic step();
        @(posedge mclk);
        #1;
    endtask : step

    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Guards against a hang anywhere in the sequence
    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        check = 1'b1;
        repeat (10) step();
        chk("done in reset", check_done, 1'b0);
        chk("table in reset", tbl_byte, 8'h00);
        resetn = 1'b1;
        $display("test reset finished");
        foreach (rows[i]) begin
            for (int p = 0; p < 2; p++) begin
                addr = rows[i].addr;
                lock_bits = NLB'(1) << (rows[i].idx + p);
                step();
                chk("done", check_done, 1'b1);
                chk("index", lock_index, rows[i].idx);
                chk("type", block_type, rows[i].typ);
                chk("write lock", wr_locked, p == 0);
                chk("read lock", rd_locked, p == 1 && rows[i].typ == TYPE_8K);
            end
        end
        $display("test lookup finished");
        check = 1'b0;
        addr = '0;
        lock_bits = '1;
        step();
        chk("idle done", check_done, 1'b0);
        chk("held index", lock_index, 8'h8E);
        chk("held write lock", wr_locked, 1'b0);
        $display("test hold finished");
        for (int s = 1; s <= 5; s++) begin
            for (int f = 0; f < 4; f++) begin
                tbl_section = 3'(s);
                tbl_field = 2'(f);
                step();
                chk("table byte", tbl_byte, exp_tbl[s][f]);
                if (f >= 2) begin
                    chk("decoded bit", host_bit, exp_bit[s][f-2]);
                end
            end
        end
        // Only 0, 6 and 7 are outside the section range
        for (int b = 0; b < 3; b++) begin
            for (int f = 0; f < 4; f++) begin
                tbl_section = (b == 0) ? 3'h0 : 3'(b + 5);
                tbl_field = 2'(f);
                step();
                chk("bad section", tbl_byte, 8'h00);
            end
        end
        $display("test table finished");
        check = 1'b1;
        addr = rows[5].addr;
        step();
        chk("done before reset", check_done, 1'b1);
        resetn = 1'b0;
        #1;
        chk("mid reset done", check_done, 1'b0);
        chk("mid reset index", lock_index, 8'h00);
        step();
        resetn = 1'b1;
        addr = rows[8].addr;
        step();
        chk("done after reset", check_done, 1'b1);
        chk("first after reset", lock_index, 8'h8E);
        $display("test second reset finished");
        summarize();
    end
endmodule : sector_lock_bit_map_tb_top
